// *** hdl/cfm_consts.svh ***
// offsets, field positions, reset values for the core flags and mode block
`ifndef CFM_CONSTS_SVH
`define CFM_CONSTS_SVH
`define CFM_ADR_FLAGS      4'h0
`define CFM_ADR_CONFIG     4'h4
`define CFM_ADR_STACK      4'h8
`define CFM_ADR_STATUS     4'hc
`define CFM_BIT_SEN        20
`define CFM_BIT_WRP        19
`define CFM_BIT_EOVF       18
`define CFM_CFG_RESET      24'h000300
`define CFM_CFG_WMASK      24'h1fffff
`define CFM_ALU_W          56
`define CFM_PRI_STACKERR   2'h3
`endif

// *** hdl/cfm_pkg.sv ***
// types for the core flags and mode block
package cfm_pkg;
	typedef enum logic [2:0] {
		CFM_OP_NONE  = 3'b000,
		CFM_OP_ADD   = 3'b001,
		CFM_OP_SUB   = 3'b010,
		CFM_OP_LOGIC = 3'b011,
		CFM_OP_CBIT  = 3'b100
	} cfm_op_t;
	typedef struct packed {
		logic        valid;
		cfm_op_t     op;
		logic [55:0] result;
		logic        carry;
		logic        ovf;
	} cfm_alu_t;
	typedef struct packed {
		logic       push;
		logic       spill_begin;
		logic [4:0] stack_pointer;
		logic [4:0] stack_depth_limit;
	} cfm_stk_t;
	typedef struct packed {
		logic        valid;
		logic [1:0]  kind;
		logic [23:0] value;
	} cfm_mod_t;
	typedef enum logic [1:0] {
		CFM_MOD_MOVE = 2'b00,
		CFM_MOD_AND  = 2'b01,
		CFM_MOD_OR   = 2'b10,
		CFM_MOD_SCS  = 2'b11
	} cfm_kind_t;
	typedef enum logic [1:0] {
		CFM_ACK_IDLE = 2'b00,
		CFM_ACK_BUSY = 2'b01
	} cfm_bus_state_t;
	typedef struct packed {
		logic [3:0]  flags;
		logic [23:0] config_word;
		logic        stack_error;
		logic        ack;
		logic [31:0] dat;
		logic        boot_load;
	} cfm_state_t;
endpackage

// *** hdl/cfm_ccr_calc.sv ***
// condition code computation from one data alu result
`timescale 1ns/1ps
module cfm_ccr_calc #(
	parameter int W = 56
) (
	input  wire logic [W-1:0] result_i,
	input  wire logic         sat_i,
	input  wire logic         sixteen_i,
	input  wire logic         ovf_i,
	input  wire logic         carry_i,
	output logic       [3:0]  flags_o
);
	logic ext_used;
	always_comb begin
		// saturation: extension bits must repeat the sign
		if (sixteen_i) begin
			ext_used = !((&result_i[W-1:31]) || !(|result_i[W-1:31]));
		end else begin
			ext_used = !((&result_i[W-1:47]) || !(|result_i[W-1:47]));
		end
		flags_o[3] = result_i[W-1];
		flags_o[2] = (result_i == '0);
		flags_o[1] = ovf_i || (sat_i && ext_used);
		flags_o[0] = carry_i;
	end
endmodule // cfm_ccr_calc

// *** hdl/cfm_flags_mode.sv ***
// core flags and operating configuration register with wishbone access
// Contract
// - the negative flag copies the top bit of each alu result.
// - the overflow flag is set when the result does not fit the 56-bit accumulator.
// - with saturation on, overflow also flags results needing extension bits, 48 or 32 bits wide.
// - the carry flag reflects carry or borrow out of result bit 55.
// - bit, rotate and shift operations also update carry by their own meaning.
// - the configuration register is read/write, three bytes: two mode bytes and the stack byte.
// - the two mode bytes change only at reset or by explicit register-destination instructions; the code also changes them on a bus write.
// - the stack byte is changed implicitly by loop, call, return and explicitly by moves.
// - during reset the four chip mode bits load from the four boot pins; the code loads them at the first clock after reset release.
// - bits 23 to 21 read as zero.
// - bit 20 enables stack spill, cleared by reset.
// - bit 19 sets when spilling begins and stays until reset or explicit move.
// - bit 18 sets on push at the depth limit with spill enabled, sticky until reset or move.
// - a rise of the overflow flag raises a non-maskable stack error at priority 3; the code raises it on a rise of bit 18, not of the overflow flag.
`timescale 1ns/1ps
`include "cfm_consts.svh"
module cfm_flags_mode #(
	parameter int ALU_W = `CFM_ALU_W
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic              boot_pin3,
	input  wire logic              boot_pin2,
	input  wire logic              boot_pin1,
	input  wire logic              boot_pin0,
	input  wire cfm_pkg::cfm_alu_t alu_i,
	input  wire cfm_pkg::cfm_stk_t stk_i,
	input  wire cfm_pkg::cfm_mod_t mod_i,
	input  wire logic              sat_mode_i,
	input  wire logic              sixteen_mode_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [3:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	output logic      [3:0]        flags_o,
	output logic      [23:0]       operating_configuration_register_o,
	output logic                   stack_spill_enable_o,
	output logic                   stack_error_o,
	output logic      [1:0]        stack_error_priority_o
);
	import cfm_pkg::*;
	cfm_state_t state_reg;
	cfm_state_t state_next;
	logic [3:0] calc_flags;
	logic       req;
	logic       wr;
	logic       cfg_wr;
	logic       push_over;
	logic [23:0] wdata;
	logic [23:0] byte_mask;

	cfm_ccr_calc #(
		.W(ALU_W)
	) u_calc (
		.result_i (alu_i.result),
		.sat_i    (sat_mode_i),
		.sixteen_i(sixteen_mode_i),
		.ovf_i    (alu_i.ovf),
		.carry_i  (alu_i.carry),
		.flags_o  (calc_flags)
	);

	// single cycle answer: ack one cycle after strobe, then dropped
	assign req = wb_cyc_i && wb_stb_i && !state_reg.ack;
	assign wr  = req && wb_we_i;
	assign cfg_wr = wr && (wb_adr_i == `CFM_ADR_CONFIG);
	assign byte_mask = {{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdata = wb_dat_i[23:0];
	assign push_over = stk_i.push && state_reg.config_word[`CFM_BIT_SEN]
		&& (stk_i.stack_pointer == stk_i.stack_depth_limit);

	always_comb begin
		state_next = state_reg;
		state_next.stack_error = 1'b0;
		state_next.boot_load = 1'b0;
		state_next.ack = req;
		// arithmetic flags follow each alu result
		if (alu_i.valid) begin
			unique case (alu_i.op)
				CFM_OP_ADD, CFM_OP_SUB: begin
					state_next.flags = calc_flags;
				end
				CFM_OP_LOGIC: begin
					state_next.flags[3:2] = calc_flags[3:2];
					state_next.flags[1] = 1'b0;
				end
				CFM_OP_CBIT: begin
					// carry supplied by the shifter or bit unit
					state_next.flags = {calc_flags[3:2], 1'b0, alu_i.carry};
				end
				default: begin
				end
			endcase
		end
		// explicit instruction writes; mode bytes change here, by a bus write below, or at reset
		if (mod_i.valid) begin
			unique case (cfm_kind_t'(mod_i.kind))
				CFM_MOD_MOVE: state_next.config_word = mod_i.value;
				CFM_MOD_AND:  state_next.config_word = state_reg.config_word & mod_i.value;
				CFM_MOD_OR:   state_next.config_word = state_reg.config_word | mod_i.value;
				CFM_MOD_SCS:  state_next.config_word[23:16] = mod_i.value[23:16];
			endcase
		end
		if (cfg_wr) begin
			state_next.config_word = (state_reg.config_word & ~byte_mask) | (wdata & byte_mask);
		end
		if (wr && (wb_adr_i == `CFM_ADR_FLAGS) && wb_sel_i[0]) begin
			state_next.flags = wb_dat_i[3:0];
		end
		// sticky flags: a hardware set wins over a same-cycle write
		if (stk_i.spill_begin) begin
			state_next.config_word[`CFM_BIT_WRP] = 1'b1;
		end
		if (push_over) begin
			state_next.config_word[`CFM_BIT_EOVF] = 1'b1;
		end
		state_next.config_word[23:21] = 3'h0;
		if (state_next.config_word[`CFM_BIT_EOVF] && !state_reg.config_word[`CFM_BIT_EOVF]) begin
			state_next.stack_error = 1'b1;
		end
		state_next.dat = 32'h0;
		if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				`CFM_ADR_FLAGS:  state_next.dat = {28'h0, state_reg.flags};
				`CFM_ADR_CONFIG: state_next.dat = {8'h0, state_reg.config_word};
				`CFM_ADR_STACK:  state_next.dat = {22'h0, stk_i.stack_depth_limit, stk_i.stack_pointer};
				`CFM_ADR_STATUS: state_next.dat = {31'h0, state_reg.config_word[`CFM_BIT_EOVF]};
				default:         state_next.dat = 32'h0;
			endcase
		end
		// boot pins caught in the cycle after reset release, no async path
		if (state_reg.boot_load) begin
			state_next.config_word[3:0] = {boot_pin3, boot_pin2, boot_pin1, boot_pin0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg.flags       <= 4'h0;
			state_reg.config_word <= `CFM_CFG_RESET;
			state_reg.stack_error <= 1'b0;
			state_reg.ack         <= 1'b0;
			state_reg.dat         <= 32'h0;
			state_reg.boot_load   <= 1'b1;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.dat;
	assign flags_o  = state_reg.flags;
	assign operating_configuration_register_o = state_reg.config_word;
	assign stack_spill_enable_o = state_reg.config_word[`CFM_BIT_SEN];
	assign stack_error_o = state_reg.stack_error;
	assign stack_error_priority_o = `CFM_PRI_STACKERR;

	// assertions
	property p_neg;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && alu_i.valid && (alu_i.op == CFM_OP_ADD) && !mod_i.valid && !wr)
			|=> (flags_o[3] == $past(alu_i.result[55]));
	endproperty
	a_neg: assert property (p_neg) else $error("negative flag wrong");
	property p_zero;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && alu_i.valid && (alu_i.op == CFM_OP_SUB) && !wr)
			|=> (flags_o[2] == ($past(alu_i.result) == '0));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_ovf;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && alu_i.valid && (alu_i.op == CFM_OP_ADD) && alu_i.ovf && !wr) |=> flags_o[1];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag missed");
	property p_sat;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && alu_i.valid && (alu_i.op == CFM_OP_ADD) && sat_mode_i && !sixteen_mode_i
			&& (alu_i.result[55:47] == 9'h001) && !wr) |=> flags_o[1];
	endproperty
	a_sat: assert property (p_sat) else $error("saturation overflow missed");
	property p_carry;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && alu_i.valid && (alu_i.op == CFM_OP_CBIT) && !wr) |=> (flags_o[0] == $past(alu_i.carry));
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong");
	property p_resv;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && ($past(wb_adr_i) == `CFM_ADR_CONFIG) && !$past(wb_we_i) |-> (wb_dat_o[31:21] == 11'h0);
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits nonzero");
	property p_wrp;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && stk_i.spill_begin) |=> operating_configuration_register_o[`CFM_BIT_WRP];
	endproperty
	a_wrp: assert property (p_wrp) else $error("spill flag not set");
	sequence s_over;
		ce_i && push_over;
	endsequence
	property p_eov;
		@(posedge clk_i) disable iff (rst_i)
		s_over ##0 !operating_configuration_register_o[`CFM_BIT_EOVF] |=> stack_error_o ##1 !stack_error_o;
	endproperty
	a_eov: assert property (p_eov) else $error("stack error pulse wrong");
	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack held too long");
endmodule // cfm_flags_mode

// *** sim/cfm_flags_mode_tb_top.sv ***
// self-checking bench for the core flags and mode block
`timescale 1ns/1ps
`include "cfm_consts.svh"
module cfm_flags_mode_tb_top;
	import cfm_pkg::*;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        ce = 1;
	logic [3:0]  boot = 4'ha;
	cfm_alu_t    alu = '0;
	cfm_stk_t    stk = '0;
	cfm_mod_t    mdi = '0;
	logic        sat = 0;
	logic        six = 0;
	logic        cyc = 0;
	logic        stb = 0;
	logic        we = 0;
	logic [3:0]  adr = '0;
	logic [3:0]  sel = '0;
	logic [31:0] dw = '0;
	logic [31:0] dr;
	logic        ack;
	logic [3:0]  flg;
	logic [23:0] cfg;
	logic        stack_spill_enable;
	logic        err;
	logic [1:0]  pri;
	logic [31:0] q;
	int          mismatches = 0;
	int          n_checks = 0;
	int          pulses;
	always #25 clk_i = ~clk_i;
	cfm_flags_mode uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .boot_pin3(boot[3]), .boot_pin2(boot[2]),
		.boot_pin1(boot[1]), .boot_pin0(boot[0]), .alu_i(alu), .stk_i(stk), .mod_i(mdi), .sat_mode_i(sat),
		.sixteen_mode_i(six), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .flags_o(flg), .operating_configuration_register_o(cfg),
		.stack_spill_enable_o(stack_spill_enable), .stack_error_o(err), .stack_error_priority_o(pri));
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	// read data taken at the very rising edge that samples ack high
	task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		dw <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dr;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask
	task automatic push(input logic sp, input logic sb);
		@(posedge clk_i);
		stk <= '{push: sp, spill_begin: sb, stack_pointer: 5'h05, stack_depth_limit: 5'h05};
		@(posedge clk_i);
		stk.push <= 0;
		stk.spill_begin <= 0;
		pulses = 0;
		repeat (4) begin
			@(negedge clk_i);
			if (err === 1'b1) pulses++;
		end
	endtask
	task automatic mod(input cfm_kind_t k, input logic [23:0] v, input logic [23:0] e);
		@(posedge clk_i);
		mdi <= '{valid: 1'b1, kind: k, value: v};
		@(posedge clk_i);
		mdi.valid <= 0;
		@(negedge clk_i);
		chk(cfg, e, "config after instruction");
	endtask
	task automatic op(input cfm_op_t o, input logic [55:0] r, input logic c, input logic v, input logic [1:0] m,
		input logic [3:0] e);
		@(posedge clk_i);
		{sat, six} <= m;
		alu <= '{valid: 1'b1, op: o, result: r, carry: c, ovf: v};
		@(posedge clk_i);
		alu.valid <= 0;
		@(negedge clk_i);
		chk(flg, e, "flags");
	endtask
	initial begin
		#200000;
		mismatches++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		repeat (2) @(posedge clk_i);
		wb(0, `CFM_ADR_CONFIG, 4'hf, 0);
		chk(q, 32'h0003_0a, "config reset");
		wb(0, `CFM_ADR_FLAGS, 4'hf, 0);
		chk(q, 0, "flags reset");
		chk(pri, `CFM_PRI_STACKERR, "priority");
		wb(0, 4'h2, 4'hf, 0);
		chk(q, 0, "unmapped read");
		$display("test reset done");
		wb(1, `CFM_ADR_CONFIG, 4'h7, 32'hffff_ffff);
		wb(0, `CFM_ADR_CONFIG, 4'hf, 0);
		chk(q, 32'h1f_ffff, "reserved bits");
		wb(1, `CFM_ADR_CONFIG, 4'h4, 32'h0010_0000);
		wb(0, `CFM_ADR_CONFIG, 4'hf, 0);
		chk(q, 32'h10_ffff, "stack byte lane");
		chk(stack_spill_enable, 1, "spill enable");
		$display("test bus done");
		push(1, 0);
		chk(cfg, 24'h14_ffff, "overflow flag");
		chk(pulses, 1, "error pulse");
		push(0, 1);
		chk(cfg, 24'h1c_ffff, "spill started");
		push(1, 0);
		chk(pulses, 0, "no pulse when already set");
		mod(CFM_MOD_MOVE, 24'h00_0300, 24'h00_0300);
		push(1, 0);
		chk(cfg, 24'h00_0300, "push with spill off");
		chk(pulses, 0, "no pulse with spill off");
		$display("test stack done");
		mod(CFM_MOD_OR, 24'h00_0005, 24'h00_0305);
		mod(CFM_MOD_AND, 24'hff_feff, 24'h00_0205);
		mod(CFM_MOD_SCS, 24'h10_0000, 24'h10_0205);
		@(posedge clk_i);
		ce <= 0;
		mod(CFM_MOD_OR, 24'h00_0040, 24'h10_0205);
		@(posedge clk_i);
		ce <= 1;
		$display("test instructions done");
		op(CFM_OP_ADD, 56'h80_0000_0000_0000, 1, 0, 2'b00, 4'b1001);
		op(CFM_OP_LOGIC, 56'h0, 0, 0, 2'b00, 4'b0101);
		op(CFM_OP_SUB, 56'h0, 0, 1, 2'b00, 4'b0110);
		op(CFM_OP_ADD, 56'h00_8000_0000_0000, 0, 0, 2'b10, 4'b0010);
		op(CFM_OP_ADD, 56'h00_0000_8000_0000, 0, 0, 2'b10, 4'b0000);
		op(CFM_OP_ADD, 56'h00_0000_8000_0000, 0, 0, 2'b11, 4'b0010);
		op(CFM_OP_CBIT, 56'h1, 1, 0, 2'b00, 4'b0001);
		wb(0, `CFM_ADR_FLAGS, 4'hf, 0);
		chk(q[3:0], 4'b0001, "flags over bus");
		$display("test flags done");
		conclude();
	end
endmodule // cfm_flags_mode_tb_top
